// ### hdl/spea_pkg.sv
package spea_pkg;
	// ---------------------------------------------------------------
	// register map (word aligned byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] reg_control = 8'h00;
	localparam logic [7:0] reg_status = 8'h04;
	localparam logic [7:0] reg_irq_status = 8'h08;
	localparam logic [7:0] reg_irq_enable = 8'h0c;
	localparam logic [7:0] reg_byte_count = 8'h10;
	localparam logic [7:0] reg_issue = 8'h14;
	localparam logic [7:0] reg_queued = 8'h18;
	localparam logic [7:0] reg_event = 8'h1c;
	// ---------------------------------------------------------------
	// control fields
	// ---------------------------------------------------------------
	localparam int ctl_run_bit = 0;
	localparam int ctl_fbs_bit = 1;
	localparam int ctl_gie_bit = 2;
	localparam int ctl_queued_cmd_bit = 3;
	// ---------------------------------------------------------------
	// status fields
	// ---------------------------------------------------------------
	localparam int sts_running_bit = 0;
	localparam int sts_state_lsb = 4;
	// ---------------------------------------------------------------
	// irq status fields (write one to clear)
	// ---------------------------------------------------------------
	localparam int irq_tfe_bit = 0;
	localparam int irq_ovf_bit = 1;
	localparam int irq_done_bit = 2;
	localparam int irq_nonfatal_bit = 3;
	// ---------------------------------------------------------------
	// event register fields (write one to pulse)
	// ---------------------------------------------------------------
	localparam int ev_status_err_bit = 0;
	localparam int ev_recoverable_bit = 1;
	localparam int ev_fatal_bit = 2;
	localparam int ev_done_bit = 3;
	localparam int ev_done_slot_lsb = 8;
	localparam logic [31:0] reset_word = 32'h0000_0000;
	localparam int num_slots = 32;
	typedef enum logic [2:0] {
		spea_idle = 3'b000,
		spea_status_error = 3'b001,
		spea_one_target_error = 3'b010,
		spea_halted_wait = 3'b011,
		spea_non_fatal = 3'b100,
		spea_switching_idle = 3'b101
	} spea_state_e;
endpackage

// ### hdl/spea_frame_count.sv
`timescale 1ns/1ps
module spea_frame_count #(
	parameter int count_width = 32
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic cmd_start,
	input wire logic frame_end,
	input wire logic frame_good,
	input wire logic [15:0] frame_words,
	input wire logic [15:0] desc_words_left,
	input wire logic frame_desc_irq,
	output logic [count_width-1:0] byte_count,
	output logic overflow_pulse,
	output logic desc_done_pulse
);
	// ---------------------------------------------------------------
	// per-frame accounting
	// ---------------------------------------------------------------
	// padding allowance of one word absorbs the odd-word fill
	wire logic [16:0] allowed_words = {1'b0, desc_words_left} + 17'h0_0001;
	wire logic frame_over = {1'b0, frame_words} > allowed_words;
	wire logic [15:0] counted_words = (frame_words > desc_words_left) ? desc_words_left : frame_words;
	wire logic accept = frame_end && frame_good;
	wire logic [count_width-1:0] add_bytes = count_width'({counted_words, 1'b0});

	always_ff @(posedge clock) begin
		if (sys_rst || cmd_start) begin
			byte_count <= '0;
		end else if (accept && !frame_over) begin
			byte_count <= byte_count + add_bytes;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overflow_pulse <= 1'b0;
			desc_done_pulse <= 1'b0;
		end else begin
			overflow_pulse <= accept && frame_over;
			desc_done_pulse <= accept && frame_desc_irq;
		end
	end
endmodule

// ### hdl/spea_port.sv
// The register offsets and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - error status received enters status-error state and sets task file error flag.
// - status-error goes to one-target error if switching enabled, else halted wait.
// - halted state holds until software clears port run control.
// - list running status clears on fatal error and after run control cleared.
// - recoverable error sets flag, returns to switching idle or port idle.
// - non-queued command byte count written before its issue bit clears; here the done event clears the bit without checking the count.
// - byte count counts only acknowledged sent data and good-CRC received data.
// - byte count may be refreshed after every completed data frame.
// - queued commands need no valid byte count; short transfers illegal.
// - overflow reported by overflow flag, byte count may be incomplete.
// - odd-word final frames are padded with zeros to a full dword.
// - padding word never flags overflow and is excluded from byte count.
// - descriptor exhausted only when every covering frame completed.
// - descriptor interrupt held internally until covering frame has good CRC.
// - descriptor done interrupt raised when port and global enables set.
// - prefetch hint may be used but prefetching is never required.
module spea_port #(
	parameter int count_width = 32
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic frame_end,
	input wire logic frame_good,
	input wire logic [15:0] frame_words,
	input wire logic [15:0] desc_words_left,
	input wire logic frame_desc_irq,
	output logic port_irq,
	output logic list_running_status,
	output logic [2:0] port_state
);
	// ---------------------------------------------------------------
	// bus slave: one wait cycle, answer on second edge
	// ---------------------------------------------------------------
	logic ack;
	wire logic req = (avs_read || avs_write) && !ack;
	wire logic do_write = avs_write && ack;
	wire logic [31:0] be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire logic [31:0] wdata = avs_writedata & be_mask;
	function automatic logic spea_hit(input logic [7:0] addr, input logic [7:0] offset);
		return addr == offset;
	endfunction

	wire logic hit_control = spea_hit(avs_address, spea_pkg::reg_control);
	wire logic hit_status = spea_hit(avs_address, spea_pkg::reg_status);
	wire logic hit_irq_status = spea_hit(avs_address, spea_pkg::reg_irq_status);
	wire logic hit_irq_enable = spea_hit(avs_address, spea_pkg::reg_irq_enable);
	wire logic hit_byte_count = spea_hit(avs_address, spea_pkg::reg_byte_count);
	wire logic hit_issue = spea_hit(avs_address, spea_pkg::reg_issue);
	wire logic hit_queued = spea_hit(avs_address, spea_pkg::reg_queued);
	wire logic hit_event = spea_hit(avs_address, spea_pkg::reg_event);

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ack <= 1'b0;
		end else begin
			ack <= req;
		end
	end

	// ---------------------------------------------------------------
	// software registers
	// ---------------------------------------------------------------
	logic [31:0] control;
	logic [3:0] irq_status;
	logic [3:0] irq_enable;
	logic [31:0] command_issue_bits;
	logic [31:0] queued_active_bits;
	logic [count_width-1:0] byte_count;
	logic overflow_pulse;
	logic desc_done_pulse;
	spea_pkg::spea_state_e state;
	spea_pkg::spea_state_e next_state;

	wire logic port_run_control = control[spea_pkg::ctl_run_bit];
	wire logic frame_switching_enable = control[spea_pkg::ctl_fbs_bit];
	wire logic global_irq_enable = control[spea_pkg::ctl_gie_bit];
	wire logic queued_cmd = control[spea_pkg::ctl_queued_cmd_bit];

	wire logic ev_wr = do_write && hit_event;
	wire logic ev_status_err = ev_wr && wdata[spea_pkg::ev_status_err_bit];
	wire logic ev_recoverable = ev_wr && wdata[spea_pkg::ev_recoverable_bit];
	wire logic ev_fatal = ev_wr && wdata[spea_pkg::ev_fatal_bit];
	wire logic ev_done = ev_wr && wdata[spea_pkg::ev_done_bit];
	wire logic [4:0] ev_slot = wdata[spea_pkg::ev_done_slot_lsb +: 5];

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			control <= spea_pkg::reset_word;
		end else if (do_write && hit_control) begin
			control <= wdata;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_enable <= '0;
		end else if (do_write && hit_irq_enable) begin
			irq_enable <= wdata[3:0];
		end
	end

	// ---------------------------------------------------------------
	// sticky flags: a set in the clearing cycle wins
	// ---------------------------------------------------------------
	wire logic enter_status_err = state == spea_pkg::spea_status_error;
	wire logic enter_non_fatal = state == spea_pkg::spea_non_fatal;
	wire logic [3:0] irq_set = {enter_non_fatal, desc_done_pulse, overflow_pulse,
		enter_status_err};
	wire logic [3:0] irq_clr = (do_write && hit_irq_status) ? wdata[3:0] : 4'h0;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	// ---------------------------------------------------------------
	// command slots: writes carry only new ones
	// ---------------------------------------------------------------
	// completion clears the issue bit one cycle after the done event write;
	// the byte count is not consulted, so it is final only if its frames ended first
	logic done_q;
	logic [4:0] done_slot_q;
	wire logic [31:0] done_mask = done_q ? (32'h0000_0001 << done_slot_q) : 32'h0000_0000;
	wire logic run_cleared = !port_run_control;

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			done_q <= 1'b0;
			done_slot_q <= '0;
		end else begin
			done_q <= ev_done;
			done_slot_q <= ev_slot;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst || run_cleared) begin
			command_issue_bits <= '0;
			queued_active_bits <= '0;
		end else begin
			command_issue_bits <= (command_issue_bits & ~done_mask) |
				((do_write && hit_issue) ? wdata : 32'h0000_0000);
			queued_active_bits <= (queued_active_bits & ~(queued_cmd ? done_mask : 32'h0)) |
				((do_write && hit_queued) ? wdata : 32'h0000_0000);
		end
	end

	// ---------------------------------------------------------------
	// byte counting and descriptor interrupt holding
	// ---------------------------------------------------------------
	spea_frame_count #(
		.count_width(count_width)
	) u_count (
		.clock(clock),
		.sys_rst(sys_rst),
		.cmd_start(do_write && hit_issue && (wdata != 32'h0)),
		.frame_end(frame_end),
		.frame_good(frame_good),
		.frame_words(frame_words),
		.desc_words_left(desc_words_left),
		.frame_desc_irq(frame_desc_irq),
		.byte_count(byte_count),
		.overflow_pulse(overflow_pulse),
		.desc_done_pulse(desc_done_pulse)
	);

	// ---------------------------------------------------------------
	// error state machine
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			spea_pkg::spea_idle, spea_pkg::spea_switching_idle: begin
				if (ev_status_err) begin
					next_state = spea_pkg::spea_status_error;
				end else if (ev_fatal) begin
					next_state = spea_pkg::spea_halted_wait;
				end else if (ev_recoverable) begin
					next_state = spea_pkg::spea_non_fatal;
				end
			end
			spea_pkg::spea_status_error: begin
				next_state = frame_switching_enable ? spea_pkg::spea_one_target_error :
					spea_pkg::spea_halted_wait;
			end
			spea_pkg::spea_one_target_error: begin
				next_state = spea_pkg::spea_switching_idle;
			end
			spea_pkg::spea_halted_wait: begin
				if (run_cleared) begin
					next_state = spea_pkg::spea_idle;
				end
			end
			spea_pkg::spea_non_fatal: begin
				next_state = frame_switching_enable ? spea_pkg::spea_switching_idle :
					spea_pkg::spea_idle;
			end
			default: begin
				next_state = spea_pkg::spea_idle;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state <= spea_pkg::spea_idle;
		end else begin
			state <= next_state;
		end
	end

	// ---------------------------------------------------------------
	// outputs, all registered
	// ---------------------------------------------------------------
	// prefetch is never done; the hint bit is simply not consulted
	wire logic halted = state == spea_pkg::spea_halted_wait;
	wire logic next_running = port_run_control && !halted;
	wire logic next_irq = global_irq_enable && |(irq_status & irq_enable);
	wire logic [31:0] status_word = {25'h0, state, 3'h0, list_running_status};
	logic [31:0] next_rdata;

	always_comb begin
		if (hit_control) begin
			next_rdata = control;
		end else if (hit_status) begin
			next_rdata = status_word;
		end else if (hit_irq_status) begin
			next_rdata = {28'h000_0000, irq_status};
		end else if (hit_irq_enable) begin
			next_rdata = {28'h000_0000, irq_enable};
		end else if (hit_byte_count) begin
			next_rdata = 32'(byte_count);
		end else if (hit_issue) begin
			next_rdata = command_issue_bits;
		end else if (hit_queued) begin
			next_rdata = queued_active_bits;
		end else begin
			next_rdata = spea_pkg::reset_word;
		end
	end

	// read data holds until the next read so a slow master still sees it
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			avs_readdata <= '0;
		end else if (avs_read && req) begin
			avs_readdata <= next_rdata;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !req;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			port_irq <= 1'b0;
		end else begin
			port_irq <= next_irq;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			list_running_status <= 1'b0;
		end else begin
			list_running_status <= next_running;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			port_state <= '0;
		end else begin
			port_state <= next_state;
		end
	end
endmodule

// ### dv/spea_port_checker.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checks
// ---------------------------------------------------------------
module spea_port_checker (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic frame_end,
	input wire logic port_irq,
	input wire logic list_running_status,
	input wire logic [2:0] port_state
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	wire logic run_off = avs_write && !avs_waitrequest && avs_address == spea_pkg::reg_control
		&& avs_byteenable[0] && !avs_writedata[0];
	a_answer_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h1c
		|-> avs_readdata == spea_pkg::reset_word) else $error("unmapped read not zero");
	a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> avs_waitrequest && !port_irq
		&& !list_running_status && port_state == 3'h0) else $error("reset values wrong");
	a_halt_hold: assert property (port_state == 3'h3 && !avs_write && !$past(avs_write)
		&& !$past(avs_write, 2) |=> port_state == 3'h3) else $error("left halted alone");
	a_status_route: assert property (port_state == 3'h1
		|-> ##[1:8] (port_state == 3'h2 || port_state == 3'h3)) else $error("bad exit");
	a_recover_idle: assert property (port_state == 3'h4
		|-> ##[1:8] (port_state == 3'h0 || port_state == 3'h5)) else $error("no recovery");
	a_run_clear: assert property (run_off |-> ##[1:3] !list_running_status)
		else $error("running kept after run cleared");
	a_irq_cause: assert property ($rose(port_irq) |-> $past(frame_end, 3) || $past(frame_end, 2)
		|| $past(avs_write, 2) || $past(avs_write, 3) || $past(avs_write, 4))
		else $error("irq without cause");
endmodule
bind spea_port spea_port_checker u_chk (.clock(clock), .sys_rst(sys_rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_end(frame_end),
	.port_irq(port_irq), .list_running_status(list_running_status), .port_state(port_state));

// ### dv/spea_link_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// drive side: sends one data frame per go, gap+1 cycles after go is taken
// ---------------------------------------------------------------
module spea_link_model (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic go,
	input wire logic [15:0] words,
	input wire logic [15:0] left,
	input wire logic good,
	input wire logic irq,
	input wire logic [2:0] gap,
	output logic frame_end,
	output logic frame_good,
	output logic frame_desc_irq,
	output logic [15:0] frame_words,
	output logic [15:0] desc_words_left,
	output logic busy
);
	logic [2:0] cnt;
	logic [15:0] w;
	logic [15:0] l;
	logic g;
	logic i;
	// qualifiers mean nothing outside frame_end, so show junk there
	assign frame_words = frame_end ? w : ~w;
	assign desc_words_left = frame_end ? l : ~l;
	assign frame_good = frame_end ? g : ~g;
	assign frame_desc_irq = frame_end ? i : ~i;
	always_ff @(posedge clock) begin
		frame_end <= 1'b0;
		if (sys_rst) begin
			busy <= 1'b0;
			{w, l, g, i} <= '0;
		end else if (go) begin
			{busy, cnt, w, l, g, i} <= {1'b1, gap, words, left, good, irq};
		end else if (busy) begin
			cnt <= cnt - 3'h1;
			busy <= cnt != 3'h0;
			frame_end <= cnt == 3'h0;
		end
	end
endmodule

// ### dv/tb.sv
`timescale 1ns/1ps
module tb;
	logic clock, sys_rst, avs_read, avs_write, avs_waitrequest, port_irq, list_running_status;
	logic frame_end, frame_good, frame_desc_irq, go, good, irq, busy;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, s;
	logic [3:0] avs_byteenable;
	logic [15:0] frame_words, desc_words_left, words, left, w;
	logic [2:0] port_state, gap;
	logic [63:0] q[$];
	int mismatches = 0, num_checks = 0, seed = 97753, bc;
	spea_port u_spea_port (.*);
	spea_link_model u_spea_link_model (.*);
	initial begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	// ---------------------------------------------------------------
	// bus, frame and compare tasks
	// ---------------------------------------------------------------
	task cmp(input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_write <= 1;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		avs_write <= 0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		q.push_back({m, e});
		@(posedge clock);
		avs_read <= 1;
		avs_address <= a;
		do @(posedge clock); while (avs_waitrequest !== 1'b0);
		avs_read <= 0;
	endtask
	task frame(input logic [15:0] fw, input logic [15:0] fl, input logic fg, input logic fi);
		@(posedge clock);
		{words, left, good, irq, go} <= {fw, fl, fg, fi, 1'b1};
		gap <= 3'($random(seed));
		@(posedge clock);
		go <= 0;
		do @(posedge clock); while (busy !== 1'b0);
	endtask
	task irq_is(input logic e);
		repeat (4) @(posedge clock);
		cmp({31'h0000_0000, e}, {31'h0000_0000, port_irq});
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// read answers are compared in arrival order
	always @(posedge clock) if (avs_read && avs_waitrequest === 1'b0 && q.size() > 0) begin
		cmp(q[0][31:0], q[0][63:32] & avs_readdata);
		void'(q.pop_front());
	end
	initial begin
		#500_000;
		mismatches++;
		end_of_test();
	end
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	initial begin
		{sys_rst, avs_read, avs_write, go, good, irq, gap} = '1;
		{avs_read, avs_write, go, good, irq, gap, words, left, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hf;
		repeat (6) @(posedge clock);
		sys_rst <= 0;
		for (int a = 0; a < 36; a += 4) if (a != 28) rd(a[7:0], 32'hffff_ffff, 32'h0000_0000);
		$display("test reset done");
		for (int f = 0; f < 2; f++) begin
			wr(spea_pkg::reg_control, f ? 32'h0000_0003 : 32'h0000_0001);
			rd(spea_pkg::reg_status, 32'h0000_0001, 32'h0000_0001);
			wr(spea_pkg::reg_event, 32'h0000_0002);
			rd(spea_pkg::reg_irq_status, 32'h0000_0008, 32'h0000_0008);
			rd(spea_pkg::reg_status, 32'h0000_0070, f ? 32'h0000_0050 : 32'h0000_0000);
			wr(spea_pkg::reg_event, 32'h0000_0001);
			repeat (2) @(posedge clock);
			cmp(f ? 32'h0000_0002 : 32'h0000_0003, {29'h0000_0000, port_state});
			rd(spea_pkg::reg_irq_status, 32'h0000_0001, 32'h0000_0001);
			rd(spea_pkg::reg_status, 32'h0000_0070, f ? 32'h0000_0050 : 32'h0000_0030);
			rd(spea_pkg::reg_status, 32'h0000_0070, f ? 32'h0000_0050 : 32'h0000_0030);
			wr(spea_pkg::reg_control, 32'h0000_0000);
			rd(spea_pkg::reg_status, 32'h0000_0071, f ? 32'h0000_0050 : 32'h0000_0000);
			wr(spea_pkg::reg_irq_status, 32'h0000_000f);
			rd(spea_pkg::reg_irq_status, 32'h0000_000f, 32'h0000_0000);
		end
		wr(spea_pkg::reg_control, 32'h0000_0001);
		wr(spea_pkg::reg_event, 32'h0000_0004);
		rd(spea_pkg::reg_status, 32'h0000_0071, 32'h0000_0030);
		cmp(32'h0000_0000, {31'h0000_0000, list_running_status});
		wr(spea_pkg::reg_control, 32'h0000_0000);
		rd(spea_pkg::reg_status, 32'h0000_0071, 32'h0000_0000);
		$display("test error paths done");
		wr(spea_pkg::reg_control, 32'h0000_0001);
		rd(spea_pkg::reg_issue, 32'hffff_ffff, 32'h0000_0000);
		s = 32'h0000_0001 << ($random(seed) & 31);
		wr(spea_pkg::reg_issue, s);
		bc = 0;
		repeat (3) begin
			w = 16'h0002 + 16'h0002 * 16'($unsigned($random(seed)) % 8);
			frame(w, 16'h0100, 1, 0);
			bc += 2 * w;
		end
		rd(spea_pkg::reg_byte_count, 32'hffff_ffff, bc);
		frame(16'h0004, 16'h0100, 0, 0);
		frame(16'h0003, 16'h0002, 1, 0);
		rd(spea_pkg::reg_irq_status, 32'h0000_0002, 32'h0000_0000);
		wr(spea_pkg::reg_event, 32'h0000_0008 | ((31'($clog2(s))) << 8));
		rd(spea_pkg::reg_issue, 32'hffff_ffff, 32'h0000_0000);
		rd(spea_pkg::reg_byte_count, 32'hffff_ffff, bc + 4);
		frame(16'h0006, 16'h0002, 1, 0);
		rd(spea_pkg::reg_irq_status, 32'h0000_0002, 32'h0000_0002);
		wr(spea_pkg::reg_irq_status, 32'h0000_000f);
		wr(spea_pkg::reg_queued, s);
		wr(spea_pkg::reg_issue, s);
		rd(spea_pkg::reg_queued, 32'hffff_ffff, s);
		wr(spea_pkg::reg_control, 32'h0000_0009);
		wr(spea_pkg::reg_event, 32'h0000_0008 | ((31'($clog2(s))) << 8));
		rd(spea_pkg::reg_queued, 32'hffff_ffff, 32'h0000_0000);
		rd(spea_pkg::reg_issue, 32'hffff_ffff, 32'h0000_0000);
		$display("test byte count done");
		wr(spea_pkg::reg_irq_enable, 32'h0000_0004);
		wr(spea_pkg::reg_control, 32'h0000_0005);
		frame(16'h0004, 16'h0100, 0, 1);
		irq_is(0);
		rd(spea_pkg::reg_irq_status, 32'h0000_0004, 32'h0000_0000);
		frame(16'h0004, 16'h0100, 1, 1);
		irq_is(1);
		rd(spea_pkg::reg_irq_status, 32'h0000_0004, 32'h0000_0004);
		wr(spea_pkg::reg_control, 32'h0000_0001);
		irq_is(0);
		wr(spea_pkg::reg_control, 32'h0000_0005);
		irq_is(1);
		wr(spea_pkg::reg_irq_status, 32'h0000_0004);
		irq_is(0);
		$display("test descriptor irq done");
		end_of_test();
	end
endmodule
